// *** src/counter_map.svh ***
// register offsets, field positions, reset values and rates of the
// preset down-counter; included by the counter design files
`ifndef COUNTER_MAP_SVH
`define COUNTER_MAP_SVH

// register offsets (byte addresses)
`define CNT_OFS_CTRL 8'h00
`define CNT_OFS_CMD 8'h04
`define CNT_OFS_PRESET 8'h08
`define CNT_OFS_THRESH 8'h0C
`define CNT_OFS_STROBE_LEN 8'h10
`define CNT_OFS_COUNT 8'h14
`define CNT_OFS_IRQ_STATUS 8'h18
`define CNT_OFS_IRQ_CLEAR 8'h1C
`define CNT_OFS_IRQ_ENABLE 8'h20
`define CNT_OFS_STATE 8'h24

// control register fields
`define CNT_CTRL_SW_EN_SEL 0
`define CNT_CTRL_SW_EN 1
`define CNT_CTRL_EXT_CLK 2
`define CNT_CTRL_RELOAD 3
`define CNT_CTRL_INVERT 4
`define CNT_CTRL_W 5
`define CNT_CTRL_RESET 5'h00

// command register fields (write-only pulses)
`define CNT_CMD_START 0
`define CNT_CMD_SOFT_RST 1

// interrupt bits
`define CNT_IRQ_ZERO 0
`define CNT_IRQ_THRESH 1
`define CNT_IRQ_W 2

// state register fields
`define CNT_STATE_RUN 0
`define CNT_STATE_PENDING 1
`define CNT_STATE_STROBE 2
`define CNT_STATE_ENABLE 3

// data register reset values
`define CNT_COUNT_RESET 32'h0000_0000
`define CNT_PRESET_RESET 32'h0000_0000

// rates: internal count clock and system clock, in MHz
`define CNT_INT_CLK_MHZ 66
`define CNT_SYS_CLK_MHZ 100

// trigger must stay high for this many counting-clock periods
`define COUNTER_TRIGGER_INPUT_MIN_TICKS 2

`endif

// *** src/counter_pkg.sv ***
// types shared by the preset down-counter design files
// assumes nothing of its surroundings
package counter_pkg;

  // run state of the down-counter, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_e;

endpackage

// *** src/input_sync.sv ***
// two-flop synchroniser with rising-edge detect for one external input
// assumes the input may change at any time relative to clock
`timescale 1ns/100ps
`default_nettype none

module input_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // external pin
  input wire logic async_in,
  // synchronised level and its rising edge
  output logic level,
  output logic rise
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // first flop feeds only the second one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg && !last_reg;

endmodule // input_sync

`default_nettype wire

// *** src/tick_gen.sv ***
// counting-clock tick source: internal rate by phase accumulation or
// the synchronised rising edge of the external counter clock
// assumes system clock faster than either counting clock
`timescale 1ns/100ps
`include "counter_map.svh"
`default_nettype none

module tick_gen #(
  parameter int INT_MHZ = `CNT_INT_CLK_MHZ,
  parameter int SYS_MHZ = `CNT_SYS_CLK_MHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // source select and external edge
  input wire logic ext_select,
  input wire logic ext_rise,
  // one-cycle pulse per counting-clock edge
  output logic tick
);

  localparam logic [7:0] INC = 8'(INT_MHZ);
  localparam logic [7:0] MODULUS = 8'(SYS_MHZ);

  logic [7:0] acc_reg;
  logic [7:0] acc_sum;
  logic acc_wrap;
  logic [7:0] acc_next;

  // average rate exact, jitter one system clock
  assign acc_sum = acc_reg + INC;
  assign acc_wrap = acc_sum >= MODULUS;
  assign acc_next = acc_wrap ? acc_sum - MODULUS : acc_sum;

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      acc_reg <= 8'h00;
    else
      acc_reg <= acc_next;
  end

  assign tick = ext_select ? ext_rise : acc_wrap;

endmodule // tick_gen

`default_nettype wire

// *** src/preset_down_counter_strobe.sv ***
// 32-bit preset down-counter with reload, threshold and zero strobe
// assumes a register master on a plain strobe port, external pins async
// Function
// - 32-bit counter that only decrements, one step per counting-clock edge.
// - software picks internal 66 MHz clock or external clock rising edges.
// - after power-up the count stays zero until loaded and started.
// - enable only arms; counting waits for a separate start event.
// - enable from pin or software; software mode ignores the pin.
// - enable low freezes count and strobe level; high counts continuously.
// - start by software or trigger held high two counting-clock periods.
// - after a valid trigger, counting begins on the next counting edge.
// - trigger after run-down reloads the start value and restarts.
// - reaching zero raises zero interrupt and starts the strobe pulse.
// - strobe length counts counting-clock periods, below the start value.
// - strobe active high by default, software may invert it.
// - reload mode reloads at zero without gap; else stop at zero.
// - software reset any time clears count, strobe goes low at once.
// - threshold as distance from zero; equal count raises interrupt.
// - software loads a full 32-bit start value used at start and reload.
`timescale 1ns/100ps
`include "counter_map.svh"
`default_nettype none

module preset_down_counter_strobe #(
  parameter int COUNT_W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  // external control pins
  input wire logic counter_enable_input,
  input wire logic counter_trigger_input,
  input wire logic counter_external_clock_input,
  // strobe pin and interrupt
  output logic zero_strobe_output,
  output logic irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  // synchronised external pins: 0 enable, 1 trigger, 2 clock
  logic [2:0] pin_raw;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;

  assign pin_raw = {counter_external_clock_input, counter_trigger_input,
                    counter_enable_input};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      input_sync u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pin_raw[gi]),
        .level(pin_level[gi]),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  // registers
  logic [`CNT_CTRL_W-1:0] ctrl_reg;
  logic [COUNT_W-1:0] preset_reg;
  logic [COUNT_W-1:0] thresh_reg;
  logic [COUNT_W-1:0] strobe_len_reg;
  logic [`CNT_IRQ_W-1:0] irq_en_reg;
  logic [`CNT_IRQ_W-1:0] irq_status_reg;
  logic [COUNT_W-1:0] count_reg;
  counter_pkg::run_state_e state_reg;
  logic start_pending_reg;
  logic [1:0] trig_ticks_reg;
  logic [COUNT_W-1:0] strobe_cnt_reg;
  logic force_low_reg;
  logic strobe_out_reg;
  logic [31:0] rdata_reg;

  // next values
  logic [COUNT_W-1:0] count_next;
  counter_pkg::run_state_e state_next;
  logic start_pending_next;
  logic [1:0] trig_ticks_next;
  logic [COUNT_W-1:0] strobe_cnt_next;
  logic force_low_next;
  logic strobe_level_next;
  logic [`CNT_IRQ_W-1:0] irq_status_next;
  logic [31:0] rdata_next;

  // register port decode
  wire wr_ctrl = wr_strobe && hit(addr, `CNT_OFS_CTRL);
  wire wr_cmd = wr_strobe && hit(addr, `CNT_OFS_CMD);
  wire wr_preset = wr_strobe && hit(addr, `CNT_OFS_PRESET);
  wire wr_thresh = wr_strobe && hit(addr, `CNT_OFS_THRESH);
  wire wr_len = wr_strobe && hit(addr, `CNT_OFS_STROBE_LEN);
  wire wr_irq_clr = wr_strobe && hit(addr, `CNT_OFS_IRQ_CLEAR);
  wire wr_irq_en = wr_strobe && hit(addr, `CNT_OFS_IRQ_ENABLE);

  wire cmd_start = wr_cmd && wdata[`CNT_CMD_START];
  wire cmd_soft_rst = wr_cmd && wdata[`CNT_CMD_SOFT_RST];

  // configuration
  wire sw_en_sel = ctrl_reg[`CNT_CTRL_SW_EN_SEL];
  wire reload_mode = ctrl_reg[`CNT_CTRL_RELOAD];
  wire strobe_inv = ctrl_reg[`CNT_CTRL_INVERT];

  // counting clock
  logic tick;

  tick_gen u_tick (
    .clock(clock),
    .rst(rst),
    .ext_select(ctrl_reg[`CNT_CTRL_EXT_CLK]),
    .ext_rise(pin_rise[2]),
    .tick(tick)
  );

  // effective enable; pin ignored in software mode
  wire eff_en = sw_en_sel ? ctrl_reg[`CNT_CTRL_SW_EN] : pin_level[0];
  wire step = tick && eff_en;

  // trigger qualification counts counting-clock edges while high
  wire trig_high = pin_level[1];
  wire trig_valid = trig_high && tick &&
                    (trig_ticks_reg == 2'(`COUNTER_TRIGGER_INPUT_MIN_TICKS - 1));
  wire idle = state_reg == counter_pkg::ST_IDLE;
  wire running = state_reg == counter_pkg::ST_RUN;

  // start consumed on a later counting edge, only while enabled
  wire start_go = idle && start_pending_reg && step;
  wire run_step = running && step;
  wire [COUNT_W-1:0] count_dec = count_reg - 1'b1;
  wire zero_event = run_step && (count_reg <= 1);
  wire thr_event = run_step && (count_reg != '0) &&
                   (count_dec == thresh_reg);
  wire strobe_busy = strobe_cnt_reg != '0;

  assign trig_ticks_next =
    !trig_high ? 2'b00 :
    (tick && trig_ticks_reg != 2'(`COUNTER_TRIGGER_INPUT_MIN_TICKS)) ?
      trig_ticks_reg + 2'b01 :
    trig_ticks_reg;

  // set by command or qualified trigger, only while stopped
  assign start_pending_next =
    cmd_soft_rst ? 1'b0 :
    start_go ? 1'b0 :
    (idle && (cmd_start || trig_valid)) ? 1'b1 :
    start_pending_reg;

  assign count_next =
    cmd_soft_rst ? `CNT_COUNT_RESET :
    start_go ? preset_reg :
    zero_event ? (reload_mode ? preset_reg : `CNT_COUNT_RESET) :
    run_step ? count_dec :
    count_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      counter_pkg::ST_IDLE: begin
        if (start_go)
          state_next = counter_pkg::ST_RUN;
      end
      counter_pkg::ST_RUN: begin
        if (zero_event && !reload_mode)
          state_next = counter_pkg::ST_IDLE;
      end
      // an illegal code falls back to idle rather than hanging
      default: state_next = counter_pkg::ST_IDLE;
    endcase
    if (cmd_soft_rst)
      state_next = counter_pkg::ST_IDLE;
  end

  // strobe length in counting-clock periods, frozen while disabled
  assign strobe_cnt_next =
    cmd_soft_rst ? '0 :
    zero_event ? strobe_len_reg :
    (step && strobe_busy) ? strobe_cnt_reg - 1'b1 :
    strobe_cnt_reg;

  // after soft reset pin sits low regardless of polarity
  assign force_low_next =
    cmd_soft_rst ? 1'b1 :
    zero_event ? 1'b0 :
    force_low_reg;

  assign strobe_level_next = force_low_next ? 1'b0 :
    ((strobe_cnt_next != '0) ^ strobe_inv);

  // sticky events; a new event beats a clear in the same cycle
  wire [`CNT_IRQ_W-1:0] irq_events = {thr_event, zero_event};
  wire [`CNT_IRQ_W-1:0] irq_clr =
    wr_irq_clr ? wdata[`CNT_IRQ_W-1:0] : '0;
  assign irq_status_next = irq_events | (irq_status_reg & ~irq_clr);

  // read mux; unmapped and write-only offsets read zero
  wire [31:0] state_word = {28'h0000000, eff_en, strobe_busy,
                            start_pending_reg, running};
  assign rdata_next =
    !rd_strobe ? 32'h0000_0000 :
    hit(addr, `CNT_OFS_CTRL) ? 32'(ctrl_reg) :
    hit(addr, `CNT_OFS_PRESET) ? 32'(preset_reg) :
    hit(addr, `CNT_OFS_THRESH) ? 32'(thresh_reg) :
    hit(addr, `CNT_OFS_STROBE_LEN) ? 32'(strobe_len_reg) :
    hit(addr, `CNT_OFS_COUNT) ? 32'(count_reg) :
    hit(addr, `CNT_OFS_IRQ_STATUS) ? 32'(irq_status_reg) :
    hit(addr, `CNT_OFS_IRQ_ENABLE) ? 32'(irq_en_reg) :
    hit(addr, `CNT_OFS_STATE) ? state_word :
    32'h0000_0000;

  // software-written configuration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `CNT_CTRL_RESET;
      preset_reg <= `CNT_PRESET_RESET;
      thresh_reg <= '0;
      strobe_len_reg <= '0;
      irq_en_reg <= '0;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= wdata[`CNT_CTRL_W-1:0];
      if (wr_preset)
        preset_reg <= wdata[COUNT_W-1:0];
      if (wr_thresh)
        thresh_reg <= wdata[COUNT_W-1:0];
      if (wr_len)
        strobe_len_reg <= wdata[COUNT_W-1:0];
      if (wr_irq_en)
        irq_en_reg <= wdata[`CNT_IRQ_W-1:0];
    end
  end

  // counting core
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= `CNT_COUNT_RESET;
      state_reg <= counter_pkg::ST_IDLE;
      start_pending_reg <= 1'b0;
      trig_ticks_reg <= 2'b00;
    end else begin
      count_reg <= count_next;
      state_reg <= state_next;
      start_pending_reg <= start_pending_next;
      trig_ticks_reg <= trig_ticks_next;
    end
  end

  // strobe, interrupt status and read data
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobe_cnt_reg <= '0;
      force_low_reg <= 1'b0;
      strobe_out_reg <= 1'b0;
      irq_status_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      strobe_cnt_reg <= strobe_cnt_next;
      force_low_reg <= force_low_next;
      strobe_out_reg <= strobe_level_next;
      irq_status_reg <= irq_status_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign zero_strobe_output = strobe_out_reg;
  assign irq = |(irq_status_reg & irq_en_reg);

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence trig_qualified;
    trig_high && tick && trig_ticks_reg == 2'b01;
  endsequence

  sequence armed_then_edge;
    start_pending_reg && idle && !cmd_soft_rst ##0 step;
  endsequence

  a_count_decrement: assert property (
    run_step && count_reg > 1 && !cmd_soft_rst
    |=> count_reg == $past(count_reg) - 1)
    else $error("count did not step down by one");

  a_count_frozen: assert property (
    !step && !cmd_soft_rst && !start_go |=> $stable(count_reg))
    else $error("count changed without an enabled counting edge");

  a_trig_arms: assert property (
    (idle && !cmd_soft_rst && !start_pending_reg) ##0 trig_qualified
    |=> start_pending_reg)
    else $error("qualified trigger did not arm the start");

  a_start_loads: assert property (
    armed_then_edge |=> running && count_reg == $past(preset_reg))
    else $error("start did not load the preset on the counting edge");

  a_zero_irq: assert property (
    zero_event |=> irq_status_reg[`CNT_IRQ_ZERO])
    else $error("zero crossing did not set its interrupt");

  a_reload_gap: assert property (
    zero_event && reload_mode && !cmd_soft_rst
    |=> running && count_reg == $past(preset_reg))
    else $error("reload mode did not reload at zero");

  a_stop_zero: assert property (
    zero_event && !reload_mode && !cmd_soft_rst
    |=> idle && count_reg == '0)
    else $error("counter did not stop at zero");

  a_soft_reset: assert property (
    cmd_soft_rst |=> count_reg == '0 && !zero_strobe_output)
    else $error("software reset did not clear count and strobe");

  a_thresh_irq: assert property (
    thr_event |=> irq_status_reg[`CNT_IRQ_THRESH])
    else $error("threshold match did not set its interrupt");

  a_strobe_pulse: assert property (
    zero_event && !cmd_soft_rst && strobe_len_reg != '0
    |=> zero_strobe_output == !$past(strobe_inv))
    else $error("strobe not at active level after zero crossing");

  // polarity writes excluded: the pin follows them one cycle late
  a_strobe_frozen: assert property (
    !step && !cmd_soft_rst && $stable(strobe_inv)
    |=> $stable(zero_strobe_output))
    else $error("strobe level moved without an enabled counting edge");

endmodule // preset_down_counter_strobe

`default_nettype wire

// *** tb/pin_source.sv ***
// far-side model: enable level, trigger pulse and external count clock
// assumes the bench requests a trigger only while the clock runs
`timescale 1ns/100ps
`default_nettype none

module pin_source #(
  parameter int HALF = 3,
  parameter int TRIG_EDGES = 3
) (
  // bench requests
  input wire logic clock,
  input wire logic run_clk,
  input wire logic trig_go,
  input wire logic en_level,
  // pins of the counter
  output logic ext_en,
  output logic ext_trig,
  output var logic ext_clk
);
  int phase = 0;
  int trig_left = 0;

  initial ext_clk = 1'b0;
  assign ext_en = en_level;
  // one edge spare covers the synchroniser delay
  assign ext_trig = trig_left > 0;
  // clock stands still while not running
  always @(posedge clock) begin
    if (run_clk && phase == HALF - 1) begin
      phase <= 0;
      ext_clk <= ~ext_clk;
      if (!ext_clk && trig_left > 0) trig_left <= trig_left - 1;
    end else if (run_clk) begin
      phase <= phase + 1;
    end
    if (trig_go) trig_left <= TRIG_EDGES;
  end
endmodule // pin_source

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the preset down-counter
// assumes the counter design files and the pin model compiled before it
`timescale 1ns/100ps
`include "counter_map.svh"
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, g, e); end end

module tb;
  localparam int HALF = 3;
  logic clock, rst, wr_strobe, rd_strobe, irq, zero_strobe_output;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v, v1, pre, thr, seed;
  logic pin_en, pin_trig, pin_clk, run_clk, trig_go, en_level;
  int n_errors = 0;
  int checks_done = 0;
  int w;

  preset_down_counter_strobe uut (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rdata(rdata), .counter_enable_input(pin_en),
    .counter_trigger_input(pin_trig),
    .counter_external_clock_input(pin_clk),
    .zero_strobe_output(zero_strobe_output), .irq(irq));
  pin_source #(.HALF(HALF), .TRIG_EDGES(3)) pins (.clock(clock),
    .run_clk(run_clk), .trig_go(trig_go), .en_level(en_level),
    .ext_en(pin_en), .ext_trig(pin_trig), .ext_clk(pin_clk));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic irq_exp(logic [1:0] st, logic [1:0] en);
    return |(st & en);
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    wr_strobe <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wdata <= rnd();
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd_strobe <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask
  // waits for the strobe level, then counts cycles it stays there
  task automatic strobe_width(logic lvl, output int n);
    int k;
    k = 0;
    while (zero_strobe_output !== lvl && k < 3000) begin
      @(posedge clock);
      #1;
      k++;
    end
    n = 0;
    while (zero_strobe_output === lvl && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (k >= 3000 || n >= 3000) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic pulse_trig();
    @(posedge clock);
    trig_go <= 1'b1;
    @(posedge clock);
    trig_go <= 1'b0;
  endtask

  initial begin
    seed = 32'hCE30AED6;
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    run_clk = 1'b0;
    trig_go = 1'b0;
    en_level = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    `CHK({irq, zero_strobe_output}, 2'b00)
    rd(8'h3C, v);
    `CHK(v, 32'h0)
    v1 = rnd();
    wr(`CNT_OFS_PRESET, v1);
    rd(`CNT_OFS_PRESET, v);
    `CHK(v, v1)
    pre = 32'h8 + (rnd() & 32'hF);
    thr = 32'h1 + (rnd() % (pre - 32'h1));
    wr(`CNT_OFS_IRQ_ENABLE, 32'h3);
    wr(`CNT_OFS_PRESET, pre);
    wr(`CNT_OFS_THRESH, thr);
    wr(`CNT_OFS_STROBE_LEN, 32'h2);
    wr(`CNT_OFS_CTRL, 32'h03);
    // software enable with the pin low: armed only
    repeat (20) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    wr(`CNT_OFS_CMD, 32'h1);
    strobe_width(1'b1, w);
    `CHK(w >= 2 && w <= 4, 1'b1)
    rd(`CNT_OFS_IRQ_STATUS, v);
    `CHK(v, 32'h3)
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    wr(`CNT_OFS_IRQ_CLEAR, 32'h1);
    wr(`CNT_OFS_IRQ_ENABLE, 32'h1);
    #1;
    `CHK(irq, irq_exp(2'b10, 2'b01))
    wr(`CNT_OFS_IRQ_ENABLE, 32'h3);
    #1;
    `CHK(irq, irq_exp(2'b10, 2'b11))
    wr(`CNT_OFS_IRQ_CLEAR, 32'h3);
    #1;
    `CHK(irq, 1'b0)
    // pin enable: start pending while the pin is low
    wr(`CNT_OFS_CTRL, 32'h00);
    wr(`CNT_OFS_CMD, 32'h1);
    repeat (30) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    rd(`CNT_OFS_STATE, v);
    `CHK(v, 32'h2)
    en_level <= 1'b1;
    // short run: a small preset must not run down before the freeze
    repeat (6) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v != 32'h0 && v <= pre, 1'b1)
    // software mode with sw_en low must ignore the high pin
    wr(`CNT_OFS_CTRL, 32'h01);
    rd(`CNT_OFS_COUNT, v1);
    repeat (25) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, v1)
    wr(`CNT_OFS_CTRL, 32'h00);
    strobe_width(1'b1, w);
    wr(`CNT_OFS_IRQ_CLEAR, 32'h3);
    // inverted strobe, then a soft reset in mid-run
    wr(`CNT_OFS_CTRL, 32'h13);
    repeat (3) @(posedge clock);
    #1;
    `CHK(zero_strobe_output, 1'b1)
    wr(`CNT_OFS_CMD, 32'h1);
    strobe_width(1'b0, w);
    `CHK(w >= 2 && w <= 4, 1'b1)
    wr(`CNT_OFS_CMD, 32'h1);
    repeat (6) @(posedge clock);
    wr(`CNT_OFS_CMD, 32'h2);
    @(posedge clock);
    #1;
    `CHK(zero_strobe_output, 1'b0)
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    // reload mode never rests at zero
    wr(`CNT_OFS_CTRL, 32'h0B);
    wr(`CNT_OFS_IRQ_CLEAR, 32'h3);
    wr(`CNT_OFS_CMD, 32'h1);
    // first counting edge may lag the start by two cycles
    repeat (3) @(posedge clock);
    for (int i = 0; i < 40; i++) begin
      rd(`CNT_OFS_COUNT, v);
      `CHK(v != 32'h0 && v <= pre, 1'b1)
    end
    rd(`CNT_OFS_IRQ_STATUS, v);
    `CHK(v[`CNT_IRQ_ZERO], 1'b1)
    wr(`CNT_OFS_CMD, 32'h2);
    wr(`CNT_OFS_IRQ_CLEAR, 32'h3);
    // external clock with trigger start
    wr(`CNT_OFS_CTRL, 32'h07);
    run_clk <= 1'b1;
    pulse_trig();
    strobe_width(1'b1, w);
    `CHK(w >= 4 * HALF - 1 && w <= 4 * HALF + 1, 1'b1)
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, 32'h0)
    pulse_trig();
    repeat (40) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v != 32'h0 && v <= pre, 1'b1)
    run_clk <= 1'b0;
    repeat (10) @(posedge clock);
    rd(`CNT_OFS_COUNT, v1);
    repeat (40) @(posedge clock);
    rd(`CNT_OFS_COUNT, v);
    `CHK(v, v1)
    end_sim();
  end
endmodule // tb

`default_nettype wire
